// file: ioe_pkg.sv
/*
  Package for the five-instruction execute block: opcode encodings,
  operand field positions and widths, reset values.
  Assumes a 14-bit instruction word supplied by an external fetch stage.
*/
package ioe_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int INSTR_W = 14;
  // Opcode field and encodings, chosen for this block
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;
  localparam int OP_W = 6;
  localparam logic [OP_W-1:0] OP_INCR_SKIP = 6'h0F;
  localparam logic [OP_W-1:0] OP_OR_REG    = 6'h04;
  localparam logic [OP_W-1:0] OP_MOVE_REG  = 6'h08;
  localparam logic [OP_W-1:0] OP_STORE_ACC = 6'h00;
  localparam logic [OP_W-1:0] OP_OR_LIT    = 6'h38;
  localparam int DEST_BIT = 7;
  localparam int STORE_BIT = 7;
  localparam int LIT_HI = 7;
  localparam int ADDR_HI = 6;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;
  typedef enum logic [2:0] {
    IOE_NONE, IOE_INCR_SKIP, IOE_OR_LIT, IOE_OR_REG, IOE_MOVE_REG,
    IOE_STORE_ACC
  } ioe_op_t;
endpackage

// file: ioe_dec_if.sv
/*
  Interface carrying decoded fields from the decoder to the execute core.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface ioe_dec_if;
  import ioe_pkg::*;
  ioe_op_t              op;
  logic                 dest_reg;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    lit;
  modport dec (output op, dest_reg, addr, lit);
  modport exe (input op, dest_reg, addr, lit);
endinterface
`default_nettype wire

// file: ioe_decode.sv
/*
  Combinational instruction field decoder.
  Assumes the instruction word is stable while its valid is high.
*/
`timescale 1ns/1ns
`default_nettype none
module ioe_decode (
  input  wire logic [ioe_pkg::INSTR_W-1:0] instr,
  input  wire logic                        instr_vld,
  ioe_dec_if.dec                           dec
);
  import ioe_pkg::*;
  logic [OP_W-1:0] opc;
  assign opc = instr[OP_HI:OP_LO];
  // Field extraction is shared by every opcode
  assign dec.addr = instr[ADDR_HI:0];
  assign dec.lit = instr[LIT_HI:0];
  assign dec.dest_reg = instr[DEST_BIT];
  // Opcode match; the store form needs bit 7 set to split it off
  always_comb begin
    dec.op = IOE_NONE;
    if (instr_vld) begin
      case (opc)
        OP_INCR_SKIP: dec.op = IOE_INCR_SKIP;
        OP_OR_REG:    dec.op = IOE_OR_REG;
        OP_MOVE_REG:  dec.op = IOE_MOVE_REG;
        OP_OR_LIT:    dec.op = IOE_OR_LIT;
        OP_STORE_ACC: dec.op = instr[STORE_BIT] ? IOE_STORE_ACC : IOE_NONE;
        default:      dec.op = IOE_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: ioe_core.sv
/*
  Execute stage for increment-skip, OR literal, OR register, move
  register and store accumulator. Holds accumulator and zero flag.
  Assumes the file register read data is combinational on reg_addr and
  that the fetch stage still delivers the word after skip_next; the core squashes it itself.
  Write strobe and data are combinational so the register file commits
  in the same cycle; registering them would add a cycle to every write.
*/
`timescale 1ns/1ns
`default_nettype none
module ioe_core (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [ioe_pkg::INSTR_W-1:0] instr,
  input  wire logic                        instr_vld,
  input  wire logic [ioe_pkg::DATA_W-1:0]  reg_rdata,
  output logic      [ioe_pkg::ADDR_W-1:0]  reg_addr,
  output logic      [ioe_pkg::DATA_W-1:0]  reg_wdata,
  output logic                             reg_we,
  output logic                             skip_next,
  output logic      [ioe_pkg::DATA_W-1:0]  acc,
  output logic                             zero_flag
);
  import ioe_pkg::*;

  ioe_dec_if dec_if ();
  ioe_decode u_dec (
    .instr     (instr),
    .instr_vld (instr_vld),
    .dec       (dec_if)
  );

  logic [DATA_W-1:0] acc_ff;
  logic              zero_ff;
  logic              squash_ff;
  logic [DATA_W-1:0] result;
  logic              to_acc;
  logic              to_reg;
  logic              upd_zero;
  ioe_op_t           op_eff;

  // A squashed word executes as a no-op
  assign op_eff = squash_ff ? IOE_NONE : dec_if.op;
  assign reg_addr = dec_if.addr;

  // Result and destination steering per instruction
  always_comb begin
    result = ZERO;
    to_acc = 1'b0;
    to_reg = 1'b0;
    upd_zero = 1'b0;
    case (op_eff)
      IOE_INCR_SKIP: begin
        result = reg_rdata + ONE;
        to_acc = ~dec_if.dest_reg;
        to_reg = dec_if.dest_reg;
      end
      IOE_OR_LIT: begin
        result = acc_ff | dec_if.lit;
        to_acc = 1'b1;
        upd_zero = 1'b1;
      end
      IOE_OR_REG: begin
        result = acc_ff | reg_rdata;
        to_acc = ~dec_if.dest_reg;
        to_reg = dec_if.dest_reg;
        upd_zero = 1'b1;
      end
      IOE_MOVE_REG: begin
        result = reg_rdata;
        to_acc = ~dec_if.dest_reg;
        to_reg = dec_if.dest_reg;
        upd_zero = 1'b1;
      end
      IOE_STORE_ACC: begin
        result = acc_ff;
        to_reg = 1'b1;
      end
      default: begin
        result = ZERO;
      end
    endcase
  end

  // Register file write happens in the same cycle as the instruction
  assign reg_we = to_reg;
  assign reg_wdata = result;
  assign acc = acc_ff;
  assign zero_flag = zero_ff;
  // Skip request is combinational; the core squashes the next word itself
  assign skip_next = (op_eff == IOE_INCR_SKIP) && (result == ZERO);

  // Accumulator
  always_ff @(posedge clk) begin
    if (srst) begin
      acc_ff <= ACC_RST;
    end else if (to_acc) begin
      acc_ff <= result;
    end
  end

  // Zero flag; increment-skip and store never touch it
  always_ff @(posedge clk) begin
    if (srst) begin
      zero_ff <= 1'b0;
    end else if (upd_zero) begin
      zero_ff <= (result == ZERO);
    end
  end

  // Squash marker: the word after a zero increment becomes a no-op
  always_ff @(posedge clk) begin
    if (srst) begin
      squash_ff <= 1'b0;
    end else if (instr_vld) begin
      // Idle cycles keep the marker so the next real word is dropped
      squash_ff <= skip_next;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  incr_acc_dest_a: assert property (
    op_eff == IOE_INCR_SKIP && !dec_if.dest_reg
    |=> acc_ff == $past(reg_rdata) + ONE)
    else $error("increment result not in accumulator");
  incr_reg_dest_a: assert property (
    op_eff == IOE_INCR_SKIP && dec_if.dest_reg
    |-> reg_we && reg_wdata == reg_rdata + ONE)
    else $error("increment result not written to register");
  skip_squash_a: assert property (
    skip_next && instr_vld |=> squash_ff && !reg_we ##1 $stable(acc_ff))
    else $error("word after zero increment not squashed");
  noskip_flags_a: assert property (
    op_eff == IOE_INCR_SKIP && !skip_next
    |=> !squash_ff && $stable(zero_ff))
    else $error("nonzero increment skipped or changed flag");
  or_lit_a: assert property (
    op_eff == IOE_OR_LIT
    |=> acc_ff == ($past(acc_ff) | $past(dec_if.lit)))
    else $error("or literal result wrong");
  or_reg_a: assert property (
    op_eff == IOE_OR_REG && dec_if.dest_reg
    |-> reg_we && reg_wdata == (acc_ff | reg_rdata))
    else $error("or register write wrong");
  move_acc_a: assert property (
    op_eff == IOE_MOVE_REG && !dec_if.dest_reg
    |=> acc_ff == $past(reg_rdata))
    else $error("move to accumulator wrong");
  move_zero_a: assert property (
    op_eff == IOE_MOVE_REG && dec_if.dest_reg
    |=> zero_ff == ($past(reg_rdata) == ZERO))
    else $error("move in place left zero flag stale");
  store_acc_a: assert property (
    op_eff == IOE_STORE_ACC
    |-> reg_we && reg_wdata == acc_ff ##1 $stable(zero_ff))
    else $error("store accumulator wrong");
  zero_def_a: assert property (
    upd_zero |=> zero_ff == ($past(result) == ZERO))
    else $error("zero flag wrong");

  // Squash bookkeeping: marker held across idle cycles, squashed word inert
  squash_hold_a: assert property (
    squash_ff && !instr_vld |=> squash_ff)
    else $error("squash marker lost on idle cycle");
  squash_quiet_a: assert property (
    squash_ff |-> !reg_we && !skip_next)
    else $error("squashed word had an effect");
  squash_flags_a: assert property (
    squash_ff && instr_vld |=> $stable(acc_ff) && $stable(zero_ff))
    else $error("squashed word changed state");

  // Skip decision judged from the result, checked here against the operand
  skip_on_wrap_a: assert property (
    op_eff == IOE_INCR_SKIP && reg_rdata == ~ZERO |-> skip_next)
    else $error("wrap to zero did not skip");
  incr_run_next_a: assert property (
    op_eff == IOE_INCR_SKIP && reg_rdata != ~ZERO |-> !skip_next)
    else $error("nonzero increment asked for skip");

  // Destination steering and flags not covered above
  or_reg_acc_a: assert property (
    op_eff == IOE_OR_REG && !dec_if.dest_reg
    |=> acc_ff == ($past(acc_ff) | $past(reg_rdata)))
    else $error("or register to accumulator wrong");
  or_lit_zero_a: assert property (
    op_eff == IOE_OR_LIT
    |=> zero_ff == (($past(acc_ff) | $past(dec_if.lit)) == ZERO))
    else $error("or literal zero flag wrong");
  or_reg_zero_a: assert property (
    op_eff == IOE_OR_REG
    |=> zero_ff == (($past(acc_ff) | $past(reg_rdata)) == ZERO))
    else $error("or register zero flag wrong");
  move_self_a: assert property (
    op_eff == IOE_MOVE_REG && dec_if.dest_reg
    |-> reg_we && reg_wdata == reg_rdata)
    else $error("move in place wrote wrong value");
  store_keep_acc_a: assert property (
    op_eff == IOE_STORE_ACC |=> $stable(acc_ff))
    else $error("store accumulator changed accumulator");
  zero_untouched_a: assert property (
    op_eff inside {IOE_INCR_SKIP, IOE_STORE_ACC, IOE_NONE}
    |=> $stable(zero_ff))
    else $error("flag changed by a flag-neutral word");

  // Main scenarios
  skip_c: cover property (skip_next ##1 squash_ff);
  squash_idle_c: cover property (squash_ff && !instr_vld);
  or_zero_c: cover property (op_eff == IOE_OR_LIT && result == ZERO);
  move_self_c: cover property (op_eff == IOE_MOVE_REG && dec_if.dest_reg);
  store_c: cover property (op_eff == IOE_STORE_ACC);
endmodule
`default_nettype wire

// file: incr_or_move_instr_exec_tb_top.sv
/*
  Self-checking bench for the five-instruction execute core.
  Assumes the bench plays fetch stage and file register read port.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module incr_or_move_instr_exec_tb_top;
  import ioe_pkg::*;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic [INSTR_W-1:0] instr = '0;
  logic               instr_vld = 1'b0;
  logic [DATA_W-1:0]  reg_rdata = 8'h00;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata;
  logic               reg_we;
  logic               skip_next;
  logic [DATA_W-1:0]  acc;
  logic               zero_flag;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  int                 cycles = 0;
  // One-bit expectation constants for the run task
  localparam logic    N = 1'b0;
  localparam logic    Y = 1'b1;

  always #5 clk = ~clk;

  ioe_core DUT (.clk(clk), .srst(srst), .instr(instr),
    .instr_vld(instr_vld), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .skip_next(skip_next),
    .acc(acc), .zero_flag(zero_flag));

  // Word builder: opcode over dest and address, or over the literal
  function automatic logic [INSTR_W-1:0] mk(input logic [OP_W-1:0] op,
                                            input logic [7:0] low);
    return {op, low};
  endfunction

  // One instruction: combinational outputs mid-cycle, state after edge
  task automatic run(input logic [13:0] w, input logic [7:0] rd,
    input logic ewe, input logic [7:0] ewd, input logic esk,
    input logic [7:0] eacc, input logic ez);
    instr = w;
    reg_rdata = rd;
    instr_vld = 1'b1;
    #4;
    `CHK(reg_addr, w[6:0])
    `CHK(reg_we, ewe)
    `CHK(skip_next, esk)
    if (ewe) `CHK(reg_wdata, ewd)
    @(posedge clk);
    #1;
    `CHK(acc, eacc)
    `CHK(zero_flag, ez)
  endtask

  task automatic t_or_lit();
    run(mk(OP_OR_LIT, 8'h00), 8'h00, N, 8'h00, N, 8'h00, Y);
    run(mk(OP_OR_LIT, 8'hA5), 8'h00, N, 8'h00, N, 8'hA5, N);
  endtask

  task automatic t_or_reg();
    run(mk(OP_OR_REG, 8'hFF), 8'h5A, Y, 8'hFF, N, 8'hA5, N);
    run(mk(OP_OR_REG, 8'h03), 8'h10, N, 8'h00, N, 8'hB5, N);
  endtask

  task automatic t_move();
    run(mk(OP_MOVE_REG, 8'h92), 8'h00, Y, 8'h00, N, 8'hB5, Y);
    run(mk(OP_MOVE_REG, 8'h12), 8'h3C, N, 8'h00, N, 8'h3C, N);
  endtask

  // Flag set beforehand so a stray flag update shows
  task automatic t_store();
    run(mk(OP_MOVE_REG, 8'h80), 8'h00, Y, 8'h00, N, 8'h3C, Y);
    run(mk(OP_STORE_ACC, 8'hD5), 8'h77, Y, 8'h3C, N, 8'h3C, Y);
  endtask

  task automatic t_incr();
    run(mk(OP_INCR_SKIP, 8'h41), 8'h41, N, 8'h00, N, 8'h42, Y);
    run(mk(OP_INCR_SKIP, 8'h81), 8'h7F, Y, 8'h80, N, 8'h42, Y);
  endtask

  // Zero result squashes the next word, then flow resumes
  task automatic t_skip();
    run(mk(OP_OR_LIT, 8'h01), 8'h00, N, 8'h00, N, 8'h43, N);
    run(mk(OP_INCR_SKIP, 8'h05), 8'hFF, N, 8'h00, Y, 8'h00, N);
    run(mk(OP_OR_LIT, 8'hFF), 8'h00, N, 8'h00, N, 8'h00, N);
    run(mk(OP_OR_LIT, 8'h00), 8'h00, N, 8'h00, N, 8'h00, Y);
    run(mk(OP_INCR_SKIP, 8'h85), 8'hFF, Y, 8'h00, Y, 8'h00, Y);
    run(mk(OP_STORE_ACC, 8'h85), 8'h11, N, 8'h00, N, 8'h00, Y);
    run(mk(OP_OR_REG, 8'h05), 8'h66, N, 8'h00, N, 8'h66, N);
  endtask

  // Squash survives an idle cycle; bit 7 clear is not a store
  task automatic t_idle();
    run(mk(OP_INCR_SKIP, 8'h00), 8'hFF, N, 8'h00, Y, 8'h00, N);
    instr_vld = 1'b0;
    instr = mk(OP_OR_LIT, 8'hFF);
    #4;
    `CHK(reg_we, 1'b0)
    `CHK(skip_next, 1'b0)
    @(posedge clk);
    #1;
    `CHK(acc, 8'h00)
    run(mk(OP_OR_LIT, 8'hFF), 8'h00, N, 8'h00, N, 8'h00, N);
    run(mk(OP_STORE_ACC, 8'h05), 8'h00, N, 8'h00, N, 8'h00, N);
    run(mk(OP_OR_LIT, 8'h81), 8'h00, N, 8'h00, N, 8'h81, N);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the few dozen cycles used
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    #1;
    srst = 1'b0;
    `CHK(acc, ACC_RST)
    `CHK(zero_flag, 1'b0)
    t_or_lit();
    t_or_reg();
    t_move();
    t_store();
    t_incr();
    t_skip();
    t_idle();
    instr_vld = 1'b0;
    wrap_up();
  end
endmodule
`default_nettype wire
